/* hw/pic_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module pic_ctrl (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [3:0] WB_DAT_I,
    output logic [3:0] WB_DAT_O,
    input wire logic WB_WE_I,
    input wire logic WB_SEL_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    input wire pic_pkg::pic_events_t SRC_EVENTS,
    input wire logic [3:0] KEY_GROUP0_PINS,
    input wire logic [3:0] KEY_GROUP1_PINS,
    input wire logic WIDE_STACK_POINTER_LOAD,
    input wire logic NIBBLE_STACK_POINTER_LOAD,
    input wire logic CPU_IRQ_ENABLE,
    input wire logic RETURN_FROM_INTERRUPT,
    input wire logic NMI_IN,
    output logic SHARED_KEY_TIMER_PIN,
    output logic IRQ_REQ,
    output logic NMI_REQ,
    output logic IRQ_RETRIGGER
);

    pic_pkg::pic_bank_t mask_r;
    pic_pkg::pic_bank_t flag_r;
    pic_pkg::pic_bank_t set_vec;
    logic [3:0] key0_sel_r;
    logic [3:0] key0_cmp_r;
    logic [3:0] key1_sel_r;
    logic [3:0] key1_cmp_r;
    logic [3:0] key0_sync;
    logic [3:0] key1_sync;
    logic key0_evt;
    logic key1_evt;
    pic_pkg::pic_sp_t sp_r;
    logic ien_r;
    logic ack_r;
    logic [3:0] rdata_r;
    logic acc;
    logic wr;
    logic [3:0] wmask;
    logic stacks_ok;
    logic pending_any;

    default clocking pic_cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // ========================================================
    // wishbone classic slave, one wait state, 4-bit data
    // ========================================================
    assign acc = WB_CYC_I & WB_STB_I & ~ack_r;
    assign wr = acc & WB_WE_I & WB_SEL_I;
    assign wmask = WB_DAT_I;

    function automatic logic hit(input logic [15:0] a);
        hit = acc && (WB_ADR_I == a);
    endfunction : hit

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc;
        end
    end

    assign WB_ACK_O = ack_r;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_r <= 4'h0;
        end else if (acc) begin
            case (WB_ADR_I)
                pic_pkg::ADDR_KEY0_SEL: rdata_r <= key0_sel_r;
                pic_pkg::ADDR_KEY0_CMP: rdata_r <= key0_cmp_r;
                pic_pkg::ADDR_KEY1_SEL: rdata_r <= key1_sel_r;
                pic_pkg::ADDR_KEY1_CMP: rdata_r <= key1_cmp_r;
                pic_pkg::ADDR_PT_MASK: rdata_r <= mask_r.timer;
                pic_pkg::ADDR_SER_MASK: rdata_r <= mask_r.serial;
                pic_pkg::ADDR_K0_MASK: rdata_r <= mask_r.key0;
                pic_pkg::ADDR_K1_MASK: rdata_r <= mask_r.key1;
                pic_pkg::ADDR_TICK_MASK: rdata_r <= mask_r.tick;
                pic_pkg::ADDR_LAP_MASK: rdata_r <= mask_r.lap;
                pic_pkg::ADDR_PT_FLAG: rdata_r <= flag_r.timer;
                pic_pkg::ADDR_SER_FLAG: rdata_r <= flag_r.serial;
                pic_pkg::ADDR_K0_FLAG: rdata_r <= flag_r.key0;
                pic_pkg::ADDR_K1_FLAG: rdata_r <= flag_r.key1;
                pic_pkg::ADDR_TICK_FLAG: rdata_r <= flag_r.tick;
                pic_pkg::ADDR_LAP_FLAG: rdata_r <= flag_r.lap;
                pic_pkg::ADDR_SP_STAT: rdata_r <= {2'h0, sp_r};
                default: rdata_r <= 4'h0;
            endcase
        end
    end

    assign WB_DAT_O = rdata_r;

    // ========================================================
    // key selection and comparison registers
    // ========================================================
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            key0_sel_r <= pic_pkg::RST_SEL;
            key0_cmp_r <= pic_pkg::RST_CMP;
            key1_sel_r <= pic_pkg::RST_SEL;
            key1_cmp_r <= pic_pkg::RST_CMP;
        end else if (wr) begin
            if (hit(pic_pkg::ADDR_KEY0_SEL))
                key0_sel_r <= WB_DAT_I;
            if (hit(pic_pkg::ADDR_KEY0_CMP))
                key0_cmp_r <= WB_DAT_I;
            if (hit(pic_pkg::ADDR_KEY1_SEL))
                key1_sel_r <= WB_DAT_I;
            if (hit(pic_pkg::ADDR_KEY1_CMP))
                key1_cmp_r <= WB_DAT_I;
        end
    end

    pic_key_group #(.WIDTH(pic_pkg::KEY_W)) u_key0 (
        .clk(CLK),
        .rst(SYS_RST),
        .pins(KEY_GROUP0_PINS),
        .select_bits(key0_sel_r),
        .compare_bits(key0_cmp_r),
        .pins_sync(key0_sync),
        .event_pulse(key0_evt)
    );

    pic_key_group #(.WIDTH(pic_pkg::KEY_W)) u_key1 (
        .clk(CLK),
        .rst(SYS_RST),
        .pins(KEY_GROUP1_PINS),
        .select_bits(key1_sel_r),
        .compare_bits(key1_cmp_r),
        .pins_sync(key1_sync),
        .event_pulse(key1_evt)
    );

    // timer clock takes the same filtered level the key logic sees
    assign SHARED_KEY_TIMER_PIN = key1_sync[3];

    // ========================================================
    // mask registers; unused bits hold zero
    // ========================================================
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mask_r <= {6{pic_pkg::RST_MASK}};
        end else if (wr) begin
            if (hit(pic_pkg::ADDR_PT_MASK))
                mask_r.timer <= {2'h0, WB_DAT_I[1:0]};
            if (hit(pic_pkg::ADDR_SER_MASK))
                mask_r.serial <= {3'h0, WB_DAT_I[0]};
            if (hit(pic_pkg::ADDR_K0_MASK))
                mask_r.key0 <= {3'h0, WB_DAT_I[0]};
            if (hit(pic_pkg::ADDR_K1_MASK))
                mask_r.key1 <= {3'h0, WB_DAT_I[0]};
            if (hit(pic_pkg::ADDR_TICK_MASK))
                mask_r.tick <= WB_DAT_I;
            if (hit(pic_pkg::ADDR_LAP_MASK))
                mask_r.lap <= {2'h0, WB_DAT_I[1:0]};
        end
    end

    // ========================================================
    // pending flags: set wins over a simultaneous clear
    // ========================================================
    always_comb begin
        set_vec = '0;
        set_vec.timer[1:0] = SRC_EVENTS.timer;
        set_vec.serial[0] = SRC_EVENTS.serial;
        set_vec.key0[0] = key0_evt;
        set_vec.key1[0] = key1_evt;
        set_vec.tick = SRC_EVENTS.tick;
        set_vec.lap = {2'h0, SRC_EVENTS.lap};
    end

    function automatic logic [3:0] w1c(input logic [3:0] cur,
                                       input logic [3:0] set,
                                       input logic clr_en,
                                       input logic [3:0] data);
        w1c = (cur & ~(clr_en ? data : 4'h0)) | set;
    endfunction : w1c

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flag_r <= {6{pic_pkg::RST_FLAG}};
        end else begin
            // masks do not gate setting
            flag_r.timer <= w1c(flag_r.timer, set_vec.timer,
                wr && hit(pic_pkg::ADDR_PT_FLAG), wmask);
            flag_r.serial <= w1c(flag_r.serial, set_vec.serial,
                wr && hit(pic_pkg::ADDR_SER_FLAG), wmask);
            flag_r.key0 <= w1c(flag_r.key0, set_vec.key0,
                wr && hit(pic_pkg::ADDR_K0_FLAG), wmask);
            flag_r.key1 <= w1c(flag_r.key1, set_vec.key1,
                wr && hit(pic_pkg::ADDR_K1_FLAG), wmask);
            flag_r.tick <= w1c(flag_r.tick, set_vec.tick,
                wr && hit(pic_pkg::ADDR_TICK_FLAG), wmask);
            flag_r.lap <= w1c(flag_r.lap, set_vec.lap,
                wr && hit(pic_pkg::ADDR_LAP_FLAG), wmask);
        end
    end

    // ========================================================
    // stack pointer pairing gate
    // ========================================================
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sp_r <= pic_pkg::PIC_SP_NONE;
        end else begin
            case ({WIDE_STACK_POINTER_LOAD, NIBBLE_STACK_POINTER_LOAD})
                2'b11: sp_r <= pic_pkg::PIC_SP_BOTH;
                2'b10: begin
                    // a lone reload re-arms the wait for its partner
                    if (sp_r == pic_pkg::PIC_SP_NIBBLE)
                        sp_r <= pic_pkg::PIC_SP_BOTH;
                    else
                        sp_r <= pic_pkg::PIC_SP_WIDE;
                end
                2'b01: begin
                    if (sp_r == pic_pkg::PIC_SP_WIDE)
                        sp_r <= pic_pkg::PIC_SP_BOTH;
                    else
                        sp_r <= pic_pkg::PIC_SP_NIBBLE;
                end
                default: sp_r <= sp_r;
            endcase
        end
    end

    assign stacks_ok = (sp_r == pic_pkg::PIC_SP_BOTH);

    // ========================================================
    // request to the core
    // ========================================================
    assign pending_any = |(flag_r & mask_r);
    // level request: stays up while a flag pends, so it is seen again
    // when the core re-enables or returns
    assign IRQ_REQ = pending_any & stacks_ok;
    assign NMI_REQ = NMI_IN & stacks_ok;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ien_r <= 1'b0;
        end else begin
            ien_r <= CPU_IRQ_ENABLE;
        end
    end

    // re-raise strobe for an already-pending request: one cycle on an enable edge, held while RETURN_FROM_INTERRUPT is high
    assign IRQ_RETRIGGER = IRQ_REQ &
        ((CPU_IRQ_ENABLE & ~ien_r) | RETURN_FROM_INTERRUPT);

    // ========================================================
    // checks
    // ========================================================
    AST_FLAG_SET_UNMASKED: assert property (
        SRC_EVENTS.serial |=> flag_r.serial[0])
        else $error("serial flag not set by event");
    AST_RETRIGGER: assert property (
        (RETURN_FROM_INTERRUPT && pending_any && stacks_ok)
        |-> IRQ_RETRIGGER)
        else $error("pending request not raised again");
    AST_W1C: assert property (
        (wr && WB_ADR_I == pic_pkg::ADDR_TICK_FLAG && WB_DAT_I[3]
         && !SRC_EVENTS.tick[3]) |=> !flag_r.tick[3])
        else $error("write one did not clear flag");
    AST_W0_KEEP: assert property (
        (wr && WB_ADR_I == pic_pkg::ADDR_TICK_FLAG && !WB_DAT_I[2]
         && flag_r.tick[2]) |=> flag_r.tick[2])
        else $error("write zero changed flag");
    AST_BLOCK_UNLOADED: assert property (
        !stacks_ok |-> (!IRQ_REQ && !NMI_REQ))
        else $error("request while stacks not loaded");
    // reset must forget any earlier stack loads
    AST_RESET_BLOCK: assert property (
        $past(SYS_RST) |-> (!IRQ_REQ && !NMI_REQ))
        else $error("request right after reset");
    AST_SINGLE_RELOAD: assert property (
        (stacks_ok && WIDE_STACK_POINTER_LOAD && !NIBBLE_STACK_POINTER_LOAD)
        |=> !NMI_REQ ##0 !IRQ_REQ)
        else $error("lone reload did not block");
    AST_MASK_LAYOUT: assert property (
        mask_r.timer[3:2] == 2'h0 && mask_r.lap[3:2] == 2'h0)
        else $error("unused mask bits set");
    AST_REQ: assert property (
        (stacks_ok && flag_r.lap[1] && mask_r.lap[1]) |-> IRQ_REQ)
        else $error("request missing");
    AST_SHARED: assert property (
        SHARED_KEY_TIMER_PIN == key1_sync[3])
        else $error("shared pin differs from key view");
    AST_ACK: assert property (
        (WB_CYC_I && WB_STB_I && !ack_r) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack timing wrong");

    COV_IRQ: cover property (@(posedge CLK) disable iff (SYS_RST) IRQ_REQ);
    COV_NMI: cover property (@(posedge CLK) disable iff (SYS_RST) NMI_REQ);
    COV_RETRIG: cover property (@(posedge CLK) disable iff (SYS_RST)
        IRQ_RETRIGGER);
    COV_KEY: cover property (@(posedge CLK) disable iff (SYS_RST) key0_evt);

endmodule : pic_ctrl
`default_nettype wire

/* hw/pic_pkg.sv */
package pic_pkg;

    // ========================================================
    // register byte addresses (16-bit I/O map, one address each)
    // ========================================================
    localparam logic [15:0] ADDR_KEY0_SEL = 16'hFF20;
    localparam logic [15:0] ADDR_KEY0_CMP = 16'hFF22;
    localparam logic [15:0] ADDR_KEY1_SEL = 16'hFF24;
    localparam logic [15:0] ADDR_KEY1_CMP = 16'hFF26;
    localparam logic [15:0] ADDR_PT_MASK = 16'hFFE2;
    localparam logic [15:0] ADDR_SER_MASK = 16'hFFE3;
    localparam logic [15:0] ADDR_K0_MASK = 16'hFFE4;
    localparam logic [15:0] ADDR_K1_MASK = 16'hFFE5;
    localparam logic [15:0] ADDR_TICK_MASK = 16'hFFE6;
    localparam logic [15:0] ADDR_LAP_MASK = 16'hFFE7;
    localparam logic [15:0] ADDR_PT_FLAG = 16'hFFF2;
    localparam logic [15:0] ADDR_SER_FLAG = 16'hFFF3;
    localparam logic [15:0] ADDR_K0_FLAG = 16'hFFF4;
    localparam logic [15:0] ADDR_K1_FLAG = 16'hFFF5;
    localparam logic [15:0] ADDR_TICK_FLAG = 16'hFFF6;
    localparam logic [15:0] ADDR_LAP_FLAG = 16'hFFF7;
    // stack pointer load status (read only)
    localparam logic [15:0] ADDR_SP_STAT = 16'hFFF8;

    // ========================================================
    // field positions and widths
    // ========================================================
    localparam int PT_W = 2;
    localparam int TICK_W = 4;
    localparam int LAP_W = 2;
    localparam int KEY_W = 4;
    localparam int BIT_TICK_1HZ = 3;
    localparam int BIT_TICK_2HZ = 2;
    localparam int BIT_TICK_8HZ = 1;
    localparam int BIT_TICK_32HZ = 0;
    localparam int BIT_LAP_1S = 1;
    localparam int BIT_LAP_TENTH = 0;
    localparam int NSRC = 12;

    // ========================================================
    // reset values
    // ========================================================
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [3:0] RST_CMP = 4'hF;
    localparam logic [3:0] RST_MASK = 4'h0;
    localparam logic [3:0] RST_FLAG = 4'h0;

    // ========================================================
    // carriers
    // ========================================================
    typedef struct packed {
        logic [PT_W-1:0] timer;
        logic serial;
        logic [TICK_W-1:0] tick;
        logic [LAP_W-1:0] lap;
    } pic_events_t;

    typedef struct packed {
        logic [3:0] timer;
        logic [3:0] serial;
        logic [3:0] key0;
        logic [3:0] key1;
        logic [3:0] tick;
        logic [3:0] lap;
    } pic_bank_t;

    typedef enum logic [1:0] {
        PIC_SP_NONE,
        PIC_SP_WIDE,
        PIC_SP_NIBBLE,
        PIC_SP_BOTH
    } pic_sp_t;

endpackage : pic_pkg

/* hw/pic_key_group.sv */
`timescale 1ns/1ps
`default_nettype none

// one four-pin key group: sync, compare, select, change detect
module pic_key_group #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pins,
    input wire logic [WIDTH-1:0] select_bits,
    input wire logic [WIDTH-1:0] compare_bits,
    output logic [WIDTH-1:0] pins_sync,
    output logic event_pulse
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] stable_r;
    logic match_r;
    logic match_nxt;

    // ========================================================
    // three-stage sync; a change counts once stage 2 and 3 agree
    // ========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stable_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    stable_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign pins_sync = stable_r;

    // a selected pin that differs from its compare bit fires the group
    always_comb begin
        match_nxt = |(select_bits & (stable_r ^ compare_bits));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match_nxt;
        end
    end

    // only the rising edge of the condition is an event
    assign event_pulse = match_nxt & ~match_r;

endmodule : pic_key_group
`default_nettype wire

/* testbench/pic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ========================================================
// behavioural core: stack loads, I flag, return, acceptance
// ========================================================
module pic_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic do_wide,
    input wire logic do_nib,
    input wire logic do_ie,
    input wire logic do_return_from_interrupt,
    output logic wide_ld,
    output logic nib_ld,
    output logic ie,
    output logic return_from_interrupt,
    output var int taken
);
    always_ff @(posedge clk) begin
        if (rst) begin
            wide_ld <= 1'b0;
            nib_ld <= 1'b0;
            return_from_interrupt <= 1'b0;
            ie <= 1'b0;
            taken <= 0;
        end else begin
            wide_ld <= do_wide;
            nib_ld <= do_nib;
            return_from_interrupt <= do_return_from_interrupt;
            // accepting drops the I flag, so a held request waits for it
            if (ie && irq_req) begin
                ie <= 1'b0;
                taken <= taken + 1;
            end else if (do_ie || do_return_from_interrupt) begin
                ie <= 1'b1;
            end
        end
    end
endmodule : pic_core_model

`default_nettype wire

/* testbench/pic_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none

module pic_ctrl_test;
    logic clk, sys_rst, cyc, stb, we, sel, nmi_in, ack, rt_seen;
    logic irq, nmi, retrig, shared, wide_ld, nib_ld, ie, return_from_interrupt;
    logic do_wide, do_nib, do_ie, do_return_from_interrupt;
    logic [15:0] adr;
    logic [3:0] wdat, dat_o, k0, k1, q, v;
    logic [31:0] rng;
    pic_pkg::pic_events_t ev;
    int errors, checks, taken;

    pic_ctrl dut (.CLK(clk), .SYS_RST(sys_rst), .WB_ADR_I(adr),
        .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(sel),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .SRC_EVENTS(ev),
        .KEY_GROUP0_PINS(k0), .KEY_GROUP1_PINS(k1),
        .WIDE_STACK_POINTER_LOAD(wide_ld),
        .NIBBLE_STACK_POINTER_LOAD(nib_ld), .CPU_IRQ_ENABLE(ie),
        .RETURN_FROM_INTERRUPT(return_from_interrupt), .NMI_IN(nmi_in),
        .SHARED_KEY_TIMER_PIN(shared), .IRQ_REQ(irq), .NMI_REQ(nmi),
        .IRQ_RETRIGGER(retrig));

    pic_core_model core (.clk(clk), .rst(sys_rst), .irq_req(irq),
        .do_wide(do_wide), .do_nib(do_nib), .do_ie(do_ie),
        .do_return_from_interrupt(do_return_from_interrupt), .wide_ld(wide_ld), .nib_ld(nib_ld), .ie(ie),
        .return_from_interrupt(return_from_interrupt), .taken(taken));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (retrig === 1'b1) rt_seen <= 1'b1;

    // ========================================================
    // helpers
    // ========================================================
    task automatic give_verdict;
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_reg(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t pin got %h exp %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one classic cycle; ack is sampled before this edge's updates land
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [3:0] d, input logic s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'b11, w, s};
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            give_verdict();
        end else begin
            q = dat_o;
            {cyc, stb, we} <= 3'b000;
        end
    endtask : wb

    task automatic rd(input logic [15:0] a, input logic [3:0] exp);
        wb(1'b0, a, 4'h0, 1'b1);
        chk_reg(q, exp);
    endtask : rd

    task automatic cmd(input logic [3:0] c);
        @(posedge clk) {do_wide, do_nib, do_ie, do_return_from_interrupt} <= c;
        @(posedge clk) {do_wide, do_nib, do_ie, do_return_from_interrupt} <= 4'h0;
        tick(3);
    endtask : cmd

    task automatic pulse(input int i);
        @(posedge clk) ev <= pic_pkg::pic_events_t'(9'h001 << i);
        @(posedge clk) ev <= '0;
        tick(2);
    endtask : pulse

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // event bit i: lap 1:0, tick 5:2, serial 6, timer 8:7
    function automatic logic [15:0] faddr(input int i);
        if (i < 2) return pic_pkg::ADDR_LAP_FLAG;
        if (i < 6) return pic_pkg::ADDR_TICK_FLAG;
        if (i == 6) return pic_pkg::ADDR_SER_FLAG;
        return pic_pkg::ADDR_PT_FLAG;
    endfunction : faddr

    function automatic logic [3:0] fbit(input int i);
        if (i < 2) return 4'h1 << i;
        if (i < 6) return 4'h1 << (i - 2);
        if (i == 6) return 4'h1;
        return 4'h1 << (i - 7);
    endfunction : fbit

    function automatic logic [3:0] fvalid(input int i);
        if (i < 2 || i > 6) return 4'h3;
        return (i == 6) ? 4'h1 : 4'hF;
    endfunction : fvalid

    // ========================================================
    // main sequence
    // ========================================================
    initial begin
        {sys_rst, cyc, stb, we, sel, nmi_in, rt_seen} = 7'b1000000;
        {do_wide, do_nib, do_ie, do_return_from_interrupt} = 4'h0;
        {adr, wdat, k0, k1, ev} = {16'h0000, 4'h0, 4'hF, 4'hF, 9'h000};
        {errors, checks, rng} = {32'h0, 32'h0, 32'h0000_0028};
        tick(10);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            rd(pic_pkg::ADDR_PT_MASK + 16'(a), 4'h0);
            rd(pic_pkg::ADDR_PT_FLAG + 16'(a), 4'h0);
        end
        rd(pic_pkg::ADDR_KEY0_SEL, 4'h0);
        rd(pic_pkg::ADDR_KEY1_CMP, 4'hF);
        rd(pic_pkg::ADDR_SP_STAT, 4'h0);
        wb(1'b1, 16'hFF30, 4'hF, 1'b1);
        rd(16'hFF30, 4'h0);
        wb(1'b1, pic_pkg::ADDR_TICK_MASK, 4'hF, 1'b0);
        rd(pic_pkg::ADDR_TICK_MASK, 4'h0);
        // stacks gate everything, the non-maskable source included
        nmi_in <= 1'b1;
        wb(1'b1, pic_pkg::ADDR_TICK_MASK, 4'hF, 1'b1);
        pulse(5);
        chk_pin(irq, 1'b0);
        chk_pin(nmi, 1'b0);
        rd(pic_pkg::ADDR_TICK_FLAG, 4'h8);
        cmd(4'h8);
        chk_pin(nmi, 1'b0);
        rd(pic_pkg::ADDR_SP_STAT, 4'h1);
        cmd(4'h4);
        chk_pin(irq, 1'b1);
        chk_pin(nmi, 1'b1);
        cmd(4'h2);
        chk_pin(rt_seen, 1'b1);
        rt_seen <= 1'b0;
        cmd(4'h1);
        chk_pin(rt_seen, 1'b1);
        chk_reg(taken[3:0], 4'h2);
        cmd(4'h8);
        chk_pin(irq, 1'b0);
        chk_pin(nmi, 1'b0);
        cmd(4'h4);
        chk_pin(irq, 1'b1);
        wb(1'b1, pic_pkg::ADDR_TICK_FLAG, 4'hF, 1'b1);
        chk_pin(irq, 1'b0);
        rt_seen <= 1'b0;
        cmd(4'h2);
        chk_pin(rt_seen, 1'b0);
        {nmi_in, v} <= 5'h00;
        wb(1'b1, pic_pkg::ADDR_TICK_MASK, 4'h0, 1'b1);
        for (int k = 0; k < 18; k++) begin
            rng = xs(rng);
            v = rng[3:0];
            wb(1'b1, faddr(k % 9) - 16'h0010, v, 1'b1);
            rd(faddr(k % 9) - 16'h0010, v & fvalid(k % 9));
            pulse(k % 9);
            chk_pin(irq, (v & fbit(k % 9)) != 4'h0);
            rd(faddr(k % 9), fbit(k % 9));
            wb(1'b1, faddr(k % 9), rng[7:4] & ~fbit(k % 9), 1'b1);
            rd(faddr(k % 9), fbit(k % 9));
            wb(1'b1, faddr(k % 9), fbit(k % 9), 1'b1);
            rd(faddr(k % 9), 4'h0);
            wb(1'b1, faddr(k % 9) - 16'h0010, 4'h0, 1'b1);
        end
        // nibble first, then wide, then both in one cycle
        cmd(4'h4);
        rd(pic_pkg::ADDR_SP_STAT, 4'h2);
        cmd(4'h8);
        rd(pic_pkg::ADDR_SP_STAT, 4'h3);
        cmd(4'hC);
        rd(pic_pkg::ADDR_SP_STAT, 4'h3);
        // key groups: only selected pins that leave the idle level count
        wb(1'b1, pic_pkg::ADDR_KEY0_SEL, 4'h1, 1'b1);
        rd(pic_pkg::ADDR_KEY0_SEL, 4'h1);
        k0 <= 4'hD;
        tick(10);
        rd(pic_pkg::ADDR_K0_FLAG, 4'h0);
        k0 <= 4'hC;
        tick(10);
        rd(pic_pkg::ADDR_K0_FLAG, 4'h1);
        wb(1'b1, pic_pkg::ADDR_KEY1_SEL, 4'h8, 1'b1);
        wb(1'b1, pic_pkg::ADDR_KEY1_CMP, 4'h7, 1'b1);
        tick(10);
        rd(pic_pkg::ADDR_K1_FLAG, 4'h1);
        chk_pin(shared, 1'b1);
        k1 <= 4'h7;
        tick(10);
        chk_pin(shared, 1'b0);
        give_verdict();
    end
endmodule : pic_ctrl_test

`default_nettype wire
